// ===== logic/sktl_pkg.sv
`default_nettype none
package sktl_pkg;
	// Word indices of the register map (byte address = index * 4)
	localparam logic [2:0] SKTL_IDX_INSTR = 3'h0;
	localparam logic [2:0] SKTL_IDX_ACC = 3'h1;
	localparam logic [2:0] SKTL_IDX_REG_B = 3'h2;
	localparam logic [2:0] SKTL_IDX_INDEX_Y = 3'h3;
	localparam logic [2:0] SKTL_IDX_DPTR = 3'h4;
	localparam logic [2:0] SKTL_IDX_MEM = 3'h5;
	localparam logic [2:0] SKTL_IDX_STATUS = 3'h6;
	localparam logic [2:0] SKTL_IDX_TIMER = 3'h7;
	// Status field positions
	localparam int SKTL_ST_CARRY = 0;
	localparam int SKTL_ST_SKIP = 1;
	localparam int SKTL_ST_WORD2 = 2;
	// Timer read-back field positions
	localparam int SKTL_TM_CNT_LSB = 0;
	localparam int SKTL_TM_RLD_LSB = 8;
	// Opcodes, ten bits
	localparam logic [9:0] SKTL_OP_MEMBIT_BASE = 10'h020;
	localparam logic [9:0] SKTL_OP_MEMBIT_MASK = 10'h3fc;
	localparam logic [9:0] SKTL_OP_CARRY_TEST = 10'h02f;
	localparam logic [9:0] SKTL_OP_PORT_W1 = 10'h024;
	localparam logic [9:0] SKTL_OP_PORT_W2 = 10'h02b;
	localparam logic [9:0] SKTL_OP_TMR_LOAD = 10'h230;
	// Reset values
	localparam logic [3:0] SKTL_RST_NIB = 4'h0;
	localparam logic [7:0] SKTL_RST_TIMER = 8'h00;
	localparam logic [9:0] SKTL_RST_OP = 10'h000;
	localparam logic [31:0] SKTL_RST_RDATA = 32'h0000_0000;
	// Sequencer states
	typedef enum logic [1:0] {
		SKTL_RUN = 2'b00,
		SKTL_WORD2 = 2'b01,
		SKTL_SKIP = 2'b10,
		SKTL_SKIP_W2 = 2'b11
	} sktl_state_t;
	// Timer one counter and its reload value
	typedef struct packed {
		logic [7:0] reload;
		logic [7:0] counter;
	} sktl_timer_t;
endpackage
`default_nettype wire

// ===== logic/sktl_core.sv
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module sktl_core import sktl_pkg::*; #(
	parameter int MEM_DEPTH = 16,
	parameter int PTR_W = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Port D pins as read by the core
	input wire logic [7:0] port_d_i,
	// Timer one load values
	output sktl_timer_t timer_one_o
);
	logic [3:0] acc;
	logic [3:0] reg_b;
	logic [3:0] index_y;
	logic [PTR_W-1:0] data_pointer;
	logic [3:0] mem [MEM_DEPTH];
	logic carry_flag;
	logic [9:0] last_op;
	sktl_state_t state;
	sktl_state_t next_state;
	sktl_timer_t timer_one;
	logic ack;
	logic [31:0] rdata;

	// Bus handshake: one wait cycle, then accept
	wire req = avs_read_i | avs_write_i;
	wire accept = req & ack;
	wire [2:0] idx = avs_address_i[4:2];
	wire wr_acc = accept & avs_write_i;
	wire exec = wr_acc & (idx == SKTL_IDX_INSTR);
	wire [9:0] op = avs_writedata_i[9:0];
	assign avs_waitrequest_o = req & ~ack;
	assign avs_readdata_o = rdata;
	assign timer_one_o = timer_one;

	// Register write selects, each qualified by the accept cycle
	wire wr_sel_acc = wr_acc & (idx == SKTL_IDX_ACC);
	wire wr_sel_reg_b = wr_acc & (idx == SKTL_IDX_REG_B);
	wire wr_sel_index = wr_acc & (idx == SKTL_IDX_INDEX_Y);
	wire wr_sel_ptr = wr_acc & (idx == SKTL_IDX_DPTR);
	wire wr_sel_mem = wr_acc & (idx == SKTL_IDX_MEM);
	wire wr_sel_status = wr_acc & (idx == SKTL_IDX_STATUS);

	// Instruction decode
	wire is_mem_test = (op & SKTL_OP_MEMBIT_MASK) == SKTL_OP_MEMBIT_BASE;
	wire is_carry_test = op == SKTL_OP_CARRY_TEST;
	wire is_port_w1 = op == SKTL_OP_PORT_W1;
	wire is_tmr_load = op == SKTL_OP_TMR_LOAD;
	wire [1:0] bit_sel = op[1:0];
	wire [3:0] mem_nib = mem[data_pointer];
	wire mem_bit = mem_nib[bit_sel];
	// Index 8..15 is outside the port; treated as a set bit
	wire port_bit = index_y[3] ? 1'b1 : port_d_i[index_y[2:0]];
	wire running = state == SKTL_RUN;
	wire do_tmr_load = exec & running & is_tmr_load;

	// Status word as read back: second-word wait, skip pending, carry
	wire word2_wait = state == SKTL_WORD2;
	wire skip_pending = (state == SKTL_SKIP) | (state == SKTL_SKIP_W2);
	wire [2:0] status_bits = {word2_wait, skip_pending, carry_flag};

	// Sequencer next state
	always_comb begin
		next_state = state;
		// Nothing moves between instruction words
		if (exec) begin
			case (state)
				SKTL_RUN: begin
					if (is_mem_test) next_state = mem_bit ? SKTL_RUN : SKTL_SKIP;
					else if (is_carry_test) next_state = carry_flag ? SKTL_RUN : SKTL_SKIP;
					else if (is_port_w1) next_state = SKTL_WORD2;
					else next_state = SKTL_RUN;
				end
				SKTL_WORD2: next_state = port_bit ? SKTL_RUN : SKTL_SKIP;
				SKTL_SKIP: next_state = is_port_w1 ? SKTL_SKIP_W2 : SKTL_RUN;
				SKTL_SKIP_W2: next_state = SKTL_RUN;
				default: next_state = SKTL_RUN;
			endcase
		end
	end

	// Bus acknowledge and read data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack <= 1'b0;
			rdata <= SKTL_RST_RDATA;
		end else begin
			ack <= req & ~ack;
			// Captured in the wait cycle, so it stands at the accept edge
			if (avs_read_i & ~ack) begin
				case (idx)
					SKTL_IDX_INSTR: rdata <= {22'h0, last_op};
					SKTL_IDX_ACC: rdata <= {28'h0, acc};
					SKTL_IDX_REG_B: rdata <= {28'h0, reg_b};
					SKTL_IDX_INDEX_Y: rdata <= {28'h0, index_y};
					SKTL_IDX_DPTR: rdata <= 32'(data_pointer);
					SKTL_IDX_MEM: rdata <= {28'h0, mem_nib};
					SKTL_IDX_STATUS: rdata <= {29'h0, status_bits};
					SKTL_IDX_TIMER: rdata <= {16'h0, timer_one};
					default: rdata <= SKTL_RST_RDATA;
				endcase
			end
		end
	end

	// Sequencer and working registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= SKTL_RUN;
			acc <= SKTL_RST_NIB;
			reg_b <= SKTL_RST_NIB;
			index_y <= SKTL_RST_NIB;
			data_pointer <= '0;
			carry_flag <= 1'b0;
			last_op <= SKTL_RST_OP;
		end else begin
			state <= next_state;
			if (exec) last_op <= op;
			if (wr_sel_acc) acc <= avs_writedata_i[3:0];
			if (wr_sel_reg_b) reg_b <= avs_writedata_i[3:0];
			if (wr_sel_index) index_y <= avs_writedata_i[3:0];
			if (wr_sel_ptr) data_pointer <= avs_writedata_i[PTR_W-1:0];
			if (wr_sel_status) carry_flag <= avs_writedata_i[SKTL_ST_CARRY];
		end
	end

	// Data memory nibbles, one per entry
	for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_mem
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) mem[g] <= SKTL_RST_NIB;
			else if (wr_sel_mem & (data_pointer == PTR_W'(g)))
				mem[g] <= avs_writedata_i[3:0];
		end
	end

	// Timer one counter and reload, loaded together
	// Counting lives elsewhere; only the load path is kept here
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_one <= '{reload: SKTL_RST_TIMER, counter: SKTL_RST_TIMER};
		end else if (do_tmr_load) begin
			timer_one.counter <= {reg_b, acc};
			timer_one.reload <= {reg_b, acc};
		end
	end

	// Memory-bit test outcome
	AST_MEMBIT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && running && is_mem_test && !mem_bit |=> state == SKTL_SKIP)
		else $error("memory bit clear did not skip");
	AST_MEMBIT_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && running && is_mem_test && mem_bit |=> state == SKTL_RUN)
		else $error("memory bit set caused a skip");
	AST_ONE_WORD_TESTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && running && (is_mem_test || is_carry_test) |=> !word2_wait)
		else $error("single-word test waited for a second word");

	// Carry test outcome; the flag itself is left alone
	AST_CARRY_TEST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && running && is_carry_test |=> $stable(carry_flag)
		&& (state == ($past(carry_flag) ? SKTL_RUN : SKTL_SKIP)))
		else $error("carry test wrong outcome or carry changed");
	AST_CARRY_BUS_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!wr_sel_status |=> $stable(carry_flag))
		else $error("carry changed without a status write");

	// Port test: the second word decides on the indexed pin
	AST_PORT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && state == SKTL_WORD2 && !index_y[3] && !port_d_i[index_y[2:0]]
		|=> state == SKTL_SKIP)
		else $error("port bit clear did not skip");
	AST_PORT_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && state == SKTL_WORD2 && port_bit |=> state == SKTL_RUN)
		else $error("port bit set caused a skip");
	AST_PORT_INDEX_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && state == SKTL_WORD2 && index_y[3] |=> state == SKTL_RUN)
		else $error("index beyond the port caused a skip");
	AST_PORT_FIRST_WORD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && running && is_port_w1 |=> state == SKTL_WORD2)
		else $error("port test did not wait for its second word");
	AST_PORT_WORD2_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state == SKTL_WORD2 && !exec |=> state == SKTL_WORD2)
		else $error("port test left before its second word");

	// Timer one load
	AST_TMR_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		do_tmr_load |=> timer_one.counter[7:4] == $past(reg_b)
		&& timer_one.reload[7:4] == $past(reg_b))
		else $error("timer high nibble not from register B");
	AST_TMR_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		do_tmr_load |=> timer_one.counter[3:0] == $past(acc)
		&& timer_one.reload[3:0] == $past(acc))
		else $error("timer low nibble not from accumulator");
	AST_TMR_NOSKIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		do_tmr_load |=> state == SKTL_RUN && $stable(carry_flag))
		else $error("timer load skipped or touched carry");
	AST_TMR_ONLY_ON_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!do_tmr_load |=> $stable(timer_one))
		else $error("timer changed without a load instruction");

	// Skipped words are consumed, a port test in full
	AST_SKIP_CONSUME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && state == SKTL_SKIP && is_tmr_load |=> $stable(timer_one)
		&& state == SKTL_RUN)
		else $error("skipped instruction was executed");
	AST_SKIP_PORT_PAIR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && state == SKTL_SKIP && is_port_w1 |=> state == SKTL_SKIP_W2)
		else $error("skipped port test kept no hold on its second word");
	AST_SKIP_W2_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exec && state == SKTL_SKIP_W2 |=> state == SKTL_RUN && $stable(timer_one))
		else $error("second word of a skipped port test was executed");
endmodule
`default_nettype wire

// ===== tb/tb_skip_test_and_timer_load_ops.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] t=%0t exp=%h got=%h", $time, (e), (g)); end end
module tb_skip_test_and_timer_load_ops import sktl_pkg::*; ();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [7:0] port_d = 8'h5a;
	logic [31:0] rdata;
	logic wait_req;
	sktl_timer_t timer_one;
	logic [31:0] rd;
	logic [7:0] tim = 8'h00;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	// Device under test
	sktl_core i_dut (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_req), .port_d_i(port_d), .timer_one_o(timer_one));
	// 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			complete_run();
		end
	end
	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// One bus transfer, held until waitrequest is seen low
	task automatic bus(input logic we, input logic [2:0] idx, input logic [31:0] d);
		@(posedge clk);
		addr <= {idx, 2'b00};
		wr_en <= we;
		rd_en <= !we;
		wdata <= d;
		@(posedge clk);
		while (wait_req !== 1'b0) begin
			@(posedge clk);
		end
		rd = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task automatic wr(input logic [2:0] i, input logic [31:0] d);
		bus(1'b1, i, d);
	endtask
	task automatic rdr(input logic [2:0] i);
		bus(1'b0, i, 32'h0000_0000);
	endtask
	// Issue a test word, then a timer load that must vanish when skipped
	task automatic try_op(input logic [9:0] op, input logic sk, input logic [3:0] a);
		wr(SKTL_IDX_ACC, {28'h0000_000, a});
		wr(SKTL_IDX_INSTR, {22'h00_0000, op});
		rdr(SKTL_IDX_STATUS);
		`CHK(rd[SKTL_ST_SKIP], sk)
		wr(SKTL_IDX_INSTR, {22'h00_0000, SKTL_OP_TMR_LOAD});
		rdr(SKTL_IDX_TIMER);
		if (!sk) begin
			tim = {4'hb, a};
		end
		`CHK(rd[15:0], {tim, tim})
	endtask
	// Every bit of the addressed memory nibble
	task automatic mem_bit_test();
		wr(SKTL_IDX_DPTR, 32'h0000_0007);
		wr(SKTL_IDX_MEM, 32'h0000_0006);
		wr(SKTL_IDX_DPTR, 32'h0000_0003);
		wr(SKTL_IDX_MEM, 32'h0000_0009);
		for (int j = 0; j < 4; j++) begin
			try_op(SKTL_OP_MEMBIT_BASE | 10'(j), !(4'h9 >> j & 4'h1), 4'(j));
		end
	endtask
	// Carry clear and set; carry must survive
	task automatic carry_test();
		for (int c = 0; c < 2; c++) begin
			wr(SKTL_IDX_STATUS, 32'(c));
			try_op(SKTL_OP_CARRY_TEST, c == 0, 4'(c + 8));
			rdr(SKTL_IDX_STATUS);
			`CHK(rd[SKTL_ST_CARRY], 1'(c))
		end
	endtask
	// Port bit chosen by index, two words
	task automatic port_test();
		for (int y = 0; y < 8; y++) begin
			wr(SKTL_IDX_INDEX_Y, 32'(y));
			wr(SKTL_IDX_INSTR, {22'h00_0000, SKTL_OP_PORT_W1});
			rdr(SKTL_IDX_STATUS);
			`CHK(rd[2:1], 2'h2)
			try_op(SKTL_OP_PORT_W2, !port_d[y], 4'(y + 4));
		end
	endtask
	// Timer load with distinct nibbles and carry set
	task automatic timer_test();
		wr(SKTL_IDX_STATUS, 32'h0000_0001);
		wr(SKTL_IDX_REG_B, 32'h0000_0003);
		wr(SKTL_IDX_ACC, 32'h0000_000c);
		wr(SKTL_IDX_INSTR, {22'h00_0000, SKTL_OP_TMR_LOAD});
		rdr(SKTL_IDX_STATUS);
		`CHK(rd[2:0], 3'h1)
		rdr(SKTL_IDX_TIMER);
		`CHK(rd[15:0], 16'h3c3c)
		`CHK(16'(timer_one), 16'h3c3c)
	endtask
	// Skipped port test swallows both words; index above 7 never skips
	task automatic skip_pair_test();
		tim = 8'h3c;
		wr(SKTL_IDX_STATUS, 32'h0000_0000);
		wr(SKTL_IDX_INSTR, {22'h00_0000, SKTL_OP_CARRY_TEST});
		wr(SKTL_IDX_INSTR, {22'h00_0000, SKTL_OP_PORT_W1});
		rdr(SKTL_IDX_STATUS);
		`CHK(rd[2:0], 3'h2)
		wr(SKTL_IDX_ACC, 32'h0000_0005);
		wr(SKTL_IDX_INSTR, {22'h00_0000, SKTL_OP_TMR_LOAD});
		rdr(SKTL_IDX_TIMER);
		`CHK(rd[15:0], 16'h3c3c)
		rdr(SKTL_IDX_STATUS);
		`CHK(rd[2:0], 3'h0)
		wr(SKTL_IDX_INDEX_Y, 32'h0000_0009);
		wr(SKTL_IDX_REG_B, 32'h0000_000b);
		wr(SKTL_IDX_INSTR, {22'h00_0000, SKTL_OP_PORT_W1});
		try_op(SKTL_OP_PORT_W2, 1'b0, 4'h6);
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wr(SKTL_IDX_REG_B, 32'h0000_000b);
		mem_bit_test();
		carry_test();
		port_test();
		timer_test();
		skip_pair_test();
		complete_run();
	end
endmodule
`default_nettype wire
